// *** rtl/retimer_channel_override_ctrl.sv ***
// channel override control: registers, boost select, divider, output mux, rate check
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module retimer_channel_override_ctrl
  import retimer_ctrl_pkg::*;
#(
  parameter int unsigned WINDOW_TICKS = WINDOW_REF_TICKS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic signal_detect_i,
  input wire logic cdr_lock_i,
  input wire logic vco_div32_i,
  input wire logic [7:0] adapted_ctle_i,
  input wire logic [1:0] auto_div_code_i,
  input wire logic retimed_data_i,
  input wire logic raw_data_i,
  output logic [7:0] ctle_boost_o,
  output logic [3:0] vco_div_ratio_o,
  output logic channel_power_o,
  output logic driver_enable_o,
  output logic data_o,
  output logic retimed_sel_o,
  output logic rate_valid_o,
  output logic rate_search_step_o
);

  // software registers
  logic [7:0] ctle_boost_override_value_r;
  logic [7:0] override_ctrl_r;
  logic [7:0] divider_select_r;
  logic [7:0] output_mux_control_r;
  logic [7:0] ctle_override_ctrl_r;
  logic [7:0] low_rate_ctle_value_r;
  logic [7:0] group1_count_low_r;
  logic [7:0] group1_count_high_override_r;
  logic [7:0] count_tolerance_deltas_r;

  // synchronised pins
  logic sig_present;
  logic cdr_locked;
  logic vco_level;
  logic vco_level_d_r;
  logic vco_edge;

  // reference tick divider
  logic [7:0] ref_div_cnt_r;
  logic ref_tick_r;

  // derived selections
  logic [1:0] div_code;
  logic [3:0] div_ratio;
  logic low_rate;
  logic [7:0] ctle_nxt;
  logic mux_sel;
  logic [COUNT_W-1:0] expected_count;
  logic [3:0] count_tolerance;

  // rate checker results
  logic window_done;
  logic window_match;
  logic [COUNT_W-1:0] measured_count;
  logic [COUNT_W-1:0] measured_r;

  // read path
  logic [7:0] rd_data_nxt;

  function automatic logic [3:0] decode_ratio(input logic [1:0] code);
    logic [3:0] ratio;
    ratio = 4'h1;
    case (code)
      DIV_BY_1: ratio = 4'h1;
      DIV_BY_2: ratio = 4'h2;
      DIV_BY_4: ratio = 4'h4;
      DIV_BY_8: ratio = 4'h8;
      default: ratio = 4'h1;
    endcase
    return ratio;
  endfunction

  // pin inputs from outside the clock domain
  pin_sync3 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i({signal_detect_i, cdr_lock_i, vco_div32_i}),
    .level_o({sig_present, cdr_locked, vco_level})
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vco_level_d_r <= 1'b0;
    end else begin
      vco_level_d_r <= vco_level;
    end
  end

  // rising edges of the synchronised vco/32 clock
  assign vco_edge = vco_level && !vco_level_d_r;

  // 25 MHz internal reference as a one-cycle enable
  // one tick every REF_DIV_CYCLES clocks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_div_cnt_r <= '0;
      ref_tick_r <= 1'b0;
    end else if (ref_div_cnt_r == 8'(REF_DIV_CYCLES - 1)) begin
      ref_div_cnt_r <= '0;
      ref_tick_r <= 1'b1;
    end else begin
      ref_div_cnt_r <= ref_div_cnt_r + 1'b1;
      ref_tick_r <= 1'b0;
    end
  end

  // register writes, one flop group per register
  // read-only and unmapped addresses fall through
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctle_boost_override_value_r <= RST_CTLE_OVR_VALUE;
    end else if (wr_en_i && (addr_i == ADDR_CTLE_OVR_VALUE)) begin
      ctle_boost_override_value_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      override_ctrl_r <= RST_OVERRIDE_CTRL;
    end else if (wr_en_i && (addr_i == ADDR_OVERRIDE_CTRL)) begin
      override_ctrl_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      divider_select_r <= RST_DIVIDER_SELECT;
    end else if (wr_en_i && (addr_i == ADDR_DIVIDER_SELECT)) begin
      divider_select_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_mux_control_r <= RST_OUTPUT_MUX_CTRL;
    end else if (wr_en_i && (addr_i == ADDR_OUTPUT_MUX_CTRL)) begin
      output_mux_control_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctle_override_ctrl_r <= RST_CTLE_OVR_CTRL;
    end else if (wr_en_i && (addr_i == ADDR_CTLE_OVR_CTRL)) begin
      ctle_override_ctrl_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_rate_ctle_value_r <= RST_LOW_RATE_CTLE;
    end else if (wr_en_i && (addr_i == ADDR_LOW_RATE_CTLE)) begin
      low_rate_ctle_value_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      group1_count_low_r <= RST_GROUP1_COUNT_LOW;
    end else if (wr_en_i && (addr_i == ADDR_GROUP1_COUNT_LOW)) begin
      group1_count_low_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      group1_count_high_override_r <= RST_GROUP1_COUNT_HIGH;
    end else if (wr_en_i && (addr_i == ADDR_GROUP1_COUNT_HIGH)) begin
      group1_count_high_override_r <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_tolerance_deltas_r <= RST_COUNT_TOL;
    end else if (wr_en_i && (addr_i == ADDR_COUNT_TOL)) begin
      count_tolerance_deltas_r <= wr_data_i;
    end
  end

  // divider: software field when its enable is set, else automatic choice
  always_comb begin
    if (override_ctrl_r[BIT_DIV_OVR_EN]) begin
      // field values above three are undefined, fall back to divide by 1
      if (divider_select_r[DIV_FIELD_LSB + 2]) begin
        div_code = DIV_BY_1;
      end else begin
        div_code = divider_select_r[DIV_FIELD_LSB +: 2];
      end
    end else begin
      div_code = auto_div_code_i;
    end
    div_ratio = decode_ratio(div_code);
    low_rate = (div_code == DIV_BY_4) || (div_code == DIV_BY_8);
  end

  // boost priority: override, then fixed low-rate value, then adaptation
  // low-rate choice follows the effective divider, not the field
  always_comb begin
    if (ctle_override_ctrl_r[BIT_CTLE_OVR_EN]) begin
      ctle_nxt = ctle_boost_override_value_r;
    end else if (low_rate) begin
      ctle_nxt = low_rate_ctle_value_r;
    end else begin
      ctle_nxt = adapted_ctle_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctle_boost_o <= '0;
      vco_div_ratio_o <= 4'h1;
    end else begin
      ctle_boost_o <= ctle_nxt;
      vco_div_ratio_o <= div_ratio;
    end
  end

  // output mux: retimed unless the override selects from the field top bit
  always_comb begin
    if (override_ctrl_r[BIT_MUX_OVR_EN]) begin
      mux_sel = output_mux_control_r[BIT_MUX_SEL];
    end else begin
      mux_sel = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      channel_power_o <= 1'b0;
      driver_enable_o <= 1'b0;
      retimed_sel_o <= 1'b1;
    end else begin
      // power and driver follow the synchronised pins
      channel_power_o <= sig_present;
      driver_enable_o <= sig_present && cdr_locked;
      retimed_sel_o <= mux_sel;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= 1'b0;
    end else if (!sig_present) begin
      // muted output is held low
      data_o <= 1'b0;
    end else if (!cdr_locked) begin
      data_o <= 1'b0;
    end else if (mux_sel) begin
      data_o <= retimed_data_i;
    end else begin
      data_o <= raw_data_i;
    end
  end

  // expected count and tolerance for the rate check
  always_comb begin
    if (group1_count_high_override_r[BIT_COUNT_OVR]) begin
      expected_count = {group1_count_high_override_r[6:0], group1_count_low_r};
      count_tolerance = count_tolerance_deltas_r[TOL_G1_LSB +: 4];
    end else begin
      // built-in count with its own tolerance
      expected_count = DEFAULT_GROUP1_COUNT;
      count_tolerance = DEFAULT_TOL;
    end
  end

  rate_window_checker #(
    .WINDOW_TICKS(WINDOW_TICKS)
  ) u_rate_check (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ref_tick_i(ref_tick_r),
    .vco_edge_i(vco_edge),
    .expected_i(expected_count),
    .tolerance_i(count_tolerance),
    .done_o(window_done),
    .match_o(window_match),
    .measured_o(measured_count)
  );

  // verdict after each window; a miss asks for the next rate candidate
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_valid_o <= 1'b0;
      rate_search_step_o <= 1'b0;
      measured_r <= '0;
    end else begin
      rate_search_step_o <= window_done && !window_match;
      if (window_done) begin
        rate_valid_o <= window_match;
        measured_r <= measured_count;
      end
    end
  end

  // read mux
  always_comb begin
    rd_data_nxt = 8'h00;
    case (addr_i)
      ADDR_CTLE_OVR_VALUE: rd_data_nxt = ctle_boost_override_value_r;
      ADDR_OVERRIDE_CTRL: rd_data_nxt = override_ctrl_r;
      ADDR_DIVIDER_SELECT: rd_data_nxt = divider_select_r;
      ADDR_OUTPUT_MUX_CTRL: rd_data_nxt = output_mux_control_r;
      ADDR_CTLE_OVR_CTRL: rd_data_nxt = ctle_override_ctrl_r;
      ADDR_LOW_RATE_CTLE: rd_data_nxt = low_rate_ctle_value_r;
      ADDR_APPLIED_CTLE: rd_data_nxt = ctle_boost_o;
      ADDR_GROUP1_COUNT_LOW: rd_data_nxt = group1_count_low_r;
      ADDR_GROUP1_COUNT_HIGH: rd_data_nxt = group1_count_high_override_r;
      ADDR_COUNT_TOL: rd_data_nxt = count_tolerance_deltas_r;
      ADDR_CHANNEL_STATUS: rd_data_nxt = {4'h0, rate_valid_o, cdr_locked, sig_present, measured_r[0]};
      default: rd_data_nxt = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= rd_data_nxt;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// *** rtl/retimer_ctrl_pkg.sv ***
// constants and register map of the retimer channel override control
//
// What this block does
// - The programmed expected count replaces the default only while the override bit at the top of the high count register is one.
// - While that bit is one, the count tolerance is the low nibble of the delta register, an integer of at most 15, about the expected count over one thousand.
// - The rate checker counts edges of the VCO clock divided by 32 during 1024 cycles of the 25 MHz internal reference.
// - With the boost override bit set, the boost from the boost override register is applied instead of the adapted one.
// - A read-only register always returns the boost actually applied, adapted or overridden.
// - At VCO divide by 4 or 8 the boost does not adapt by default and the low-rate boost register is applied.
// - Without a detected input signal the channel and its output driver are powered down, muting the output.
// - With signal but no lock the output is muted; once locked, raw or retimed data go out as the mux bit and its override bit select.
// - Mux select one routes retimed data, the locked default; zero routes the raw equalizer output taken before retiming.
// - The mux override value is the single top bit, bit 7, of the mux control register, written by software.
// - Divider field bits 6:4 decode 0 to divide by 1, 1 to 2, 2 to 4 and 3 to 8.
package retimer_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned COUNT_W = 15;

  localparam logic [7:0] ADDR_CTLE_OVR_VALUE = 8'h03;
  localparam logic [7:0] ADDR_OVERRIDE_CTRL = 8'h09;
  localparam logic [7:0] ADDR_DIVIDER_SELECT = 8'h18;
  localparam logic [7:0] ADDR_OUTPUT_MUX_CTRL = 8'h1e;
  localparam logic [7:0] ADDR_CTLE_OVR_CTRL = 8'h2d;
  localparam logic [7:0] ADDR_LOW_RATE_CTLE = 8'h3a;
  localparam logic [7:0] ADDR_APPLIED_CTLE = 8'h52;
  localparam logic [7:0] ADDR_GROUP1_COUNT_LOW = 8'h62;
  localparam logic [7:0] ADDR_GROUP1_COUNT_HIGH = 8'h63;
  localparam logic [7:0] ADDR_COUNT_TOL = 8'h64;
  localparam logic [7:0] ADDR_CHANNEL_STATUS = 8'h70;

  localparam int unsigned BIT_DIV_OVR_EN = 2;
  localparam int unsigned BIT_MUX_OVR_EN = 5;
  localparam int unsigned BIT_CTLE_OVR_EN = 3;
  localparam int unsigned BIT_MUX_SEL = 7;
  localparam int unsigned BIT_COUNT_OVR = 7;
  localparam int unsigned DIV_FIELD_LSB = 4;
  localparam int unsigned MUX_FIELD_LSB = 5;
  localparam int unsigned TOL_G1_LSB = 0;

  localparam logic [7:0] RST_CTLE_OVR_VALUE = 8'h00;
  localparam logic [7:0] RST_OVERRIDE_CTRL = 8'h00;
  localparam logic [7:0] RST_DIVIDER_SELECT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_MUX_CTRL = 8'h80;
  localparam logic [7:0] RST_CTLE_OVR_CTRL = 8'h00;
  localparam logic [7:0] RST_LOW_RATE_CTLE = 8'h00;
  localparam logic [7:0] RST_GROUP1_COUNT_LOW = 8'h90;
  localparam logic [7:0] RST_GROUP1_COUNT_HIGH = 8'h33;
  localparam logic [7:0] RST_COUNT_TOL = 8'hcd;
  localparam logic [COUNT_W-1:0] DEFAULT_GROUP1_COUNT = 15'h3390;
  localparam logic [3:0] DEFAULT_TOL = 4'hd;

  localparam longint unsigned CLK_FREQ_HZ = 250000000;
  localparam longint unsigned REF_FREQ_HZ = 25000000;
  localparam int unsigned REF_DIV_CYCLES = int'(CLK_FREQ_HZ / REF_FREQ_HZ);
  localparam int unsigned WINDOW_REF_TICKS = 1024;

  typedef enum logic [1:0] {
    DIV_BY_1 = 2'b00,
    DIV_BY_2 = 2'b01,
    DIV_BY_4 = 2'b10,
    DIV_BY_8 = 2'b11
  } div_code_e;

endpackage

// *** rtl/pin_sync3.sv ***
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_o <= '0;
    end else begin
      stage1_r <= pin_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (int i = 0; i < int'(WIDTH); i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_o[i] <= stage3_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/rate_window_checker.sv ***
// counts vco/32 edges over a window of reference ticks and checks tolerance
`timescale 1ns/1ns
`default_nettype none
module rate_window_checker
  import retimer_ctrl_pkg::*;
#(
  parameter int unsigned WINDOW_TICKS = WINDOW_REF_TICKS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ref_tick_i,
  input wire logic vco_edge_i,
  input wire logic [COUNT_W-1:0] expected_i,
  input wire logic [3:0] tolerance_i,
  output logic done_o,
  output logic match_o,
  output logic [COUNT_W-1:0] measured_o
);
  logic [10:0] tick_cnt_r;
  logic [COUNT_W-1:0] edge_cnt_r;
  logic [COUNT_W-1:0] edge_cnt_nxt;
  logic [COUNT_W:0] diff;
  logic window_end;

  assign window_end = ref_tick_i && (tick_cnt_r == 11'(WINDOW_TICKS - 1));
  // saturate rather than wrap on a wildly fast clock
  assign edge_cnt_nxt = (vco_edge_i && (edge_cnt_r != '1)) ? edge_cnt_r + 1'b1 : edge_cnt_r;
  assign diff = (edge_cnt_nxt >= expected_i) ? {1'b0, edge_cnt_nxt - expected_i}
                                             : {1'b0, expected_i - edge_cnt_nxt};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_r <= '0;
    end else if (window_end) begin
      tick_cnt_r <= '0;
    end else if (ref_tick_i) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_cnt_r <= '0;
    end else if (window_end) begin
      edge_cnt_r <= '0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      match_o <= 1'b0;
      measured_o <= '0;
    end else begin
      done_o <= window_end;
      if (window_end) begin
        measured_o <= edge_cnt_nxt;
        match_o <= (diff <= {12'h000, tolerance_i});
      end
    end
  end
endmodule
`default_nettype wire

// *** test/retimer_ctrl_sva.sv ***
// assertion checker for the channel override control
`timescale 1ns/1ns
`default_nettype none
module retimer_ctrl_sva
  import retimer_ctrl_pkg::*;
#(
  parameter int unsigned WINDOW_TICKS = WINDOW_REF_TICKS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic retimed_data_i,
  input wire logic raw_data_i,
  input wire logic [7:0] ctle_boost_o,
  input wire logic [3:0] vco_div_ratio_o,
  input wire logic channel_power_o,
  input wire logic driver_enable_o,
  input wire logic data_o,
  input wire logic retimed_sel_o,
  input wire logic rate_valid_o,
  input wire logic rate_search_step_o
);
  logic bovr_r;
  logic [7:0] bval_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of the boost override registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bovr_r <= 1'b0;
      bval_r <= RST_CTLE_OVR_VALUE;
    end else if (wr_en_i && addr_i == ADDR_CTLE_OVR_CTRL) begin
      bovr_r <= wr_data_i[BIT_CTLE_OVR_EN];
    end else if (wr_en_i && addr_i == ADDR_CTLE_OVR_VALUE) begin
      bval_r <= wr_data_i;
    end
  end
  sequence s_boost_rd;
    rd_en_i && addr_i == ADDR_APPLIED_CTLE;
  endsequence
  sequence s_live2;
    driver_enable_o && $past(driver_enable_o);
  endsequence
  a_power_mute: assert property (!channel_power_o |-> !driver_enable_o && !data_o)
    else $error("output live without signal");
  a_unlocked_mute: assert property (!driver_enable_o |-> !data_o)
    else $error("data while muted");
  a_retimed_path: assert property (s_live2 ##0 (retimed_sel_o && $past(retimed_sel_o))
    |-> data_o == $past(retimed_data_i)) else $error("retimed path wrong");
  a_raw_path: assert property (s_live2 ##0 (!retimed_sel_o && !$past(retimed_sel_o))
    |-> data_o == $past(raw_data_i)) else $error("raw path wrong");
  a_read_boost: assert property (s_boost_rd |=> rd_data_o == $past(ctle_boost_o))
    else $error("readback differs from applied boost");
  a_idle_read: assert property (!rd_en_i |=> rd_data_o == 8'h00)
    else $error("read data without read");
  a_boost_ovr: assert property (bovr_r && $past(bovr_r) && $stable(bval_r) |-> ctle_boost_o == bval_r)
    else $error("override boost not applied");
  a_div_onehot: assert property ($onehot(vco_div_ratio_o))
    else $error("divider ratio not 1 2 4 8");
  a_step_pulse: assert property (rate_search_step_o |=> !rate_search_step_o)
    else $error("search step longer than one cycle");
  a_step_invalid: assert property (rate_search_step_o |-> !rate_valid_o)
    else $error("search step with valid rate");
endmodule
bind retimer_channel_override_ctrl retimer_ctrl_sva #(.WINDOW_TICKS(WINDOW_TICKS)) u_sva (
  .clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .retimed_data_i, .raw_data_i,
  .ctle_boost_o, .vco_div_ratio_o, .channel_power_o, .driver_enable_o, .data_o, .retimed_sel_o,
  .rate_valid_o, .rate_search_step_o);
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the channel override control
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import retimer_ctrl_pkg::*;
;
  localparam int WT = 8;
  localparam int NE = REF_DIV_CYCLES * WT / 8;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, adapted_ctle_i = 8'h00;
  logic wr_en_i = 1'b0, rd_en_i = 1'b0, signal_detect_i = 1'b0, cdr_lock_i = 1'b0, vco_div32_i = 1'b0;
  logic [1:0] auto_div_code_i = 2'h0;
  logic retimed_data_i = 1'b0, raw_data_i = 1'b0, vco_on = 1'b0;
  logic [7:0] rd_data_o, ctle_boost_o, d, v3, va;
  logic [3:0] vco_div_ratio_o;
  logic channel_power_o, driver_enable_o, data_o, retimed_sel_o, rate_valid_o, rate_search_step_o;
  int mismatches = 0, n_checks = 0, seed = 28544, vcnt = 0;
  logic [7:0] ra [10] = '{8'h03, 8'h09, 8'h18, 8'h1e, 8'h2d, 8'h3a, 8'h62, 8'h63, 8'h64, 8'h55};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h90, 8'h33, 8'hcd, 8'h00};
  logic [7:0] cl [7] = '{8'h0c, 8'h0d, 8'h08, 8'h07, 8'h0a, 8'h0a, 8'h0a};
  logic [7:0] ch [7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h81, 8'h00};
  logic [7:0] ct [7] = '{8'hc2, 8'hc2, 8'hc2, 8'hc2, 8'hc0, 8'hcf, 8'hcf};
  always #2 clk_i = ~clk_i;
  // vco/32 stand-in, eight clocks a period
  always @(posedge clk_i) begin
    vcnt <= (vcnt == 7) ? 0 : vcnt + 1;
    if (vco_on) vco_div32_i <= (vcnt < 4);
  end
  retimer_channel_override_ctrl #(.WINDOW_TICKS(WT)) dut (
    .clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .signal_detect_i, .cdr_lock_i,
    .vco_div32_i, .adapted_ctle_i, .auto_div_code_i, .retimed_data_i, .raw_data_i, .ctle_boost_o,
    .vco_div_ratio_o, .channel_power_o, .driver_enable_o, .data_o, .retimed_sel_o, .rate_valid_o,
    .rate_search_step_o);
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    @(posedge clk_i);
    v = rd_data_o;
  endtask
  function automatic logic [3:0] ratio(input logic [2:0] c);
    return (c > 3'd3) ? 4'h1 : 4'h1 << c[1:0];
  endfunction
  function automatic logic [7:0] boost(input logic bo, input logic [3:0] r);
    return bo ? v3 : (r[2] || r[3]) ? va : adapted_ctle_i;
  endfunction
  function automatic logic rate_ok(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] tl);
    int e, t;
    e = hi[7] ? {hi[6:0], lo} : DEFAULT_GROUP1_COUNT;
    t = hi[7] ? tl[3:0] : DEFAULT_TOL;
    return (e - NE <= t) && (NE - e <= t);
  endfunction
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    int i, n;
    logic s, l, me, ms, r, bo, dv;
    logic [2:0] c;
    logic [3:0] q;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 10; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    for (i = 0; i < 32; i++) begin
      c = i[2:0];
      dv = i[3];
      bo = i[4];
      v3 = 8'($random(seed));
      va = (c == 3'd2) ? 8'h00 : 8'($random(seed));
      adapted_ctle_i <= 8'($random(seed));
      auto_div_code_i <= 2'($random(seed));
      wr(ADDR_CTLE_OVR_VALUE, v3);
      wr(ADDR_LOW_RATE_CTLE, va);
      wr(ADDR_DIVIDER_SELECT, {1'b0, c, 4'h0});
      wr(ADDR_OVERRIDE_CTRL, {5'h0, dv, 2'h0});
      wr(ADDR_CTLE_OVR_CTRL, {4'h0, bo, 3'h0});
      repeat (3) @(posedge clk_i);
      q = ratio(dv ? c : {1'b0, auto_div_code_i});
      chk({4'h0, vco_div_ratio_o}, {4'h0, q});
      chk(ctle_boost_o, boost(bo, q));
      rd(ADDR_APPLIED_CTLE, d);
      chk(d, boost(bo, q));
      rd(ADDR_DIVIDER_SELECT, d);
      chk(d, {1'b0, c, 4'h0});
    end
    wr(ADDR_APPLIED_CTLE, ~boost(bo, q));
    rd(ADDR_APPLIED_CTLE, d);
    chk(d, boost(bo, q));
    for (i = 0; i < 16; i++) begin
      {s, l, me, ms} = i[3:0];
      r = 1'($random(seed));
      wr(ADDR_OVERRIDE_CTRL, {2'h0, me, 5'h0});
      wr(ADDR_OUTPUT_MUX_CTRL, {ms, 7'h0});
      signal_detect_i <= s;
      cdr_lock_i <= l;
      retimed_data_i <= r;
      raw_data_i <= ~r;
      repeat (8) @(posedge clk_i);
      chk({7'h0, channel_power_o}, {7'h0, s});
      chk({7'h0, driver_enable_o}, {7'h0, s & l});
      chk({7'h0, retimed_sel_o}, {7'h0, ~me | ms});
      chk({7'h0, data_o}, {7'h0, s & l & (r ^ me & ~ms)});
    end
    vco_on <= 1'b1;
    for (i = 0; i < 7; i++) begin
      wr(ADDR_GROUP1_COUNT_LOW, cl[i]);
      wr(ADDR_GROUP1_COUNT_HIGH, ch[i]);
      wr(ADDR_COUNT_TOL, ct[i]);
      dv = rate_ok(cl[i], ch[i], ct[i]);
      repeat (30 * WT) @(posedge clk_i);
      n = 0;
      repeat (10 * WT) begin
        @(posedge clk_i);
        n += rate_search_step_o;
      end
      chk({7'h0, rate_valid_o}, {7'h0, dv});
      chk(n[7:0], {7'h0, ~dv});
      rd(ADDR_CHANNEL_STATUS, d);
      chk({7'h0, d[3]}, {7'h0, dv});
    end
    stop_test();
  end
endmodule
`default_nettype wire
